// ===== shp_dev.sv
// Device end of the host port: strap detect, then an SPI slave that
// turns bursts into register read strobes and buffered register writes.
// Assumes the register file answers a read strobe within the same cycle.
module shp_dev
  import shp_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_W,
  parameter int DATA_BITS = BYTE_W
) (
  input wire logic mclk,
  input wire logic srst,
  shp_if.dev pins,
  output shp_mode_t mode,
  output logic detect_done,
  output logic rd_strobe,
  output logic [ADDR_BITS-1:0] rd_addr,
  input wire logic [DATA_BITS-1:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [ADDR_BITS-1:0] wr_addr,
  output logic [DATA_BITS-1:0] wr_data,
  output logic wr_overrun
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0] ss_s;
    logic [1:0] sck_s;
    logic [1:0] mosi_s;
    logic [1:0] sel_s;
    logic [1:0] ea_s;
    logic sck_d;
    logic [2:0] det_cnt;
    logic det_done;
    shp_mode_t mode;
    shp_dph_t ph;
    logic [2:0] bit_cnt;
    logic [DATA_BITS-1:0] rx_sh;
    logic [DATA_BITS-1:0] tx_sh;
    logic [ADDR_BITS-1:0] addr;
    logic rd_strobe;
    logic push;
    logic [ADDR_BITS+DATA_BITS-1:0] push_word;
    logic overrun;
  } shp_dev_st_t;

  shp_dev_st_t st_reg;
  shp_dev_st_t st_next;
  logic buf_in_ready;
  logic [ADDR_BITS+DATA_BITS-1:0] buf_out;
  logic spi_on;
  logic ss_act;
  logic sck_rise;
  logic sck_fall;
  logic [DATA_BITS-1:0] byte_in;

  // ****************************************************************
  // Decoded link events
  // ****************************************************************
  // Only the second synchroniser stage is looked at from here on.
  assign spi_on = st_reg.det_done && (st_reg.mode == SHP_MODE_SPI);
  assign ss_act = spi_on && !st_reg.ss_s[1];
  assign sck_rise = st_reg.sck_s[1] && !st_reg.sck_d;
  assign sck_fall = !st_reg.sck_s[1] && st_reg.sck_d;
  assign byte_in = {st_reg.rx_sh[DATA_BITS-2:0], st_reg.mosi_s[1]};

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.rd_strobe = 1'b0;
    st_next.push = 1'b0;
    st_next.overrun = 1'b0;
    st_next.ss_s = {st_reg.ss_s[0], pins.slave_select_n};
    st_next.sck_s = {st_reg.sck_s[0], pins.shared_io_five};
    st_next.mosi_s = {st_reg.mosi_s[0], pins.shared_io_six};
    st_next.sel_s = {st_reg.sel_s[0], pins.iface_sel_pin};
    st_next.ea_s = {st_reg.ea_s[0], pins.address_strap_pin};
    st_next.sck_d = st_reg.sck_s[1];

    if (!st_reg.det_done) begin
      if (st_reg.det_cnt == 3'(DETECT_WAIT - 1)) begin
        st_next.det_done = 1'b1;
        if (st_reg.sel_s[1]) begin
          st_next.mode = SHP_MODE_I2C;
        end else if (st_reg.ea_s[1]) begin
          st_next.mode = SHP_MODE_SPI;
        end else begin
          st_next.mode = SHP_MODE_UART;
        end
      end else begin
        st_next.det_cnt = st_reg.det_cnt + 3'h1;
      end
    end

    // A read answer is taken in the same cycle as its strobe.
    if (st_reg.rd_strobe) begin
      st_next.tx_sh = rd_data;
    end

    if (!ss_act) begin
      st_next.ph = SHP_DPH_ADDR;
      st_next.bit_cnt = 3'h0;
    end else begin
      if (sck_rise) begin
        st_next.rx_sh = byte_in;
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
        if (st_reg.bit_cnt == LAST_BIT) begin
          unique case (st_reg.ph)
            SHP_DPH_ADDR: begin
              st_next.addr = byte_in[ADDR_MSB:ADDR_LSB];
              if (byte_in[RW_BIT] == RW_READ) begin
                st_next.ph = SHP_DPH_READ;
                st_next.rd_strobe = 1'b1;
              end else begin
                st_next.ph = SHP_DPH_WRITE;
              end
            end
            SHP_DPH_READ: begin
              if (byte_in[RW_BIT] == RW_READ) begin
                st_next.addr = byte_in[ADDR_MSB:ADDR_LSB];
                st_next.rd_strobe = 1'b1;
              end
            end
            SHP_DPH_WRITE: begin
              st_next.push = 1'b1;
              st_next.push_word = {st_reg.addr, byte_in};
            end
          endcase
        end
      end
      if (sck_fall && st_reg.bit_cnt != 3'h0) begin
        st_next.tx_sh = {st_reg.tx_sh[DATA_BITS-2:0], 1'b0};
      end
    end

    // a full buffer loses the word
    if (st_reg.push && !buf_in_ready) begin
      st_next.overrun = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '{
        ss_s: 2'h3,
        sck_s: 2'h0,
        mosi_s: 2'h0,
        sel_s: 2'h0,
        ea_s: 2'h0,
        sck_d: 1'b0,
        det_cnt: 3'h0,
        det_done: 1'b0,
        mode: SHP_MODE_NONE,
        ph: SHP_DPH_ADDR,
        bit_cnt: 3'h0,
        rx_sh: '0,
        tx_sh: '0,
        addr: '0,
        rd_strobe: 1'b0,
        push: 1'b0,
        push_word: '0,
        overrun: 1'b0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Write buffer
  // ****************************************************************
  // Two entries absorb a short stall by the register file; the
  // serial side cannot be held, so a longer stall shows as overrun.
  shp_buf #(
    .W(ADDR_BITS + DATA_BITS)
  ) u_wbuf (
    .mclk(mclk),
    .srst(srst),
    .in_valid(st_reg.push),
    .in_ready(buf_in_ready),
    .in_data(st_reg.push_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(buf_out)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wr_addr = buf_out[ADDR_BITS+DATA_BITS-1:DATA_BITS];
  assign wr_data = buf_out[DATA_BITS-1:0];
  assign mode = st_reg.mode;
  assign detect_done = st_reg.det_done;
  assign rd_strobe = st_reg.rd_strobe;
  assign rd_addr = st_reg.addr;
  assign wr_overrun = st_reg.overrun;
  assign pins.shared_io_seven_o = ss_act ? st_reg.tx_sh[DATA_BITS-1]
                                         : IDLE_MISO;
  assign pins.shared_io_seven_oe = ss_act;
endmodule

// ===== shp_pkg.sv
// Shared constants and types for the SPI host port with interface detect.
// Assumes a single 25 MHz system clock on both ends of the link.
package shp_pkg;

  // ****************************************************************
  // Clock and link timing
  // ****************************************************************
  localparam int MCLK_HZ = 25000000;
  localparam int MCLK_PERIOD_NS = 1000000000 / MCLK_HZ;
  localparam int SPI_MAX_KBPS = 10000;
  localparam int SPI_MIN_PERIOD_NS = 1000000 / SPI_MAX_KBPS;
  // A least half period rounds up to whole clock cycles.
  localparam int SCK_MIN_HALF_RAW =
    (SPI_MIN_PERIOD_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SCK_MIN_HALF = (SCK_MIN_HALF_RAW < 1) ? 1 : SCK_MIN_HALF_RAW;
  localparam int SCK_HALF_DEF = 8;
  localparam int DETECT_WAIT = 4;

  // ****************************************************************
  // Address byte layout
  // ****************************************************************
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 6;
  localparam int RW_BIT = 7;
  localparam int ADDR_MSB = 6;
  localparam int ADDR_LSB = 1;
  localparam logic RW_READ = 1'b1;
  localparam logic ADDR_PAD = 1'b0;
  localparam logic [7:0] END_BYTE = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic IDLE_MISO = 1'b1;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    SHP_MODE_NONE,
    SHP_MODE_UART,
    SHP_MODE_SPI,
    SHP_MODE_I2C
  } shp_mode_t;

  typedef enum logic [1:0] {
    SHP_DPH_ADDR,
    SHP_DPH_READ,
    SHP_DPH_WRITE
  } shp_dph_t;

  typedef enum logic [2:0] {
    SHP_HPH_IDLE,
    SHP_HPH_SEL,
    SHP_HPH_SHIFT,
    SHP_HPH_LOAD,
    SHP_HPH_END
  } shp_hph_t;

endpackage

// ===== shp_if.sv
// Pin bundle between the host microcontroller end and the device port.
// Straps are board wiring and are driven by whoever builds the board.
interface shp_if;
  logic slave_select_n;
  logic iface_sel_pin;
  logic address_strap_pin;
  logic shared_io_five;
  logic shared_io_six;
  logic shared_io_seven_o;
  logic shared_io_seven_oe;
  logic shared_io_seven;

  // The undriven line floats high through a board pull-up.
  assign shared_io_seven = shared_io_seven_oe ? shared_io_seven_o : 1'b1;

  modport dev (
    input slave_select_n,
    input iface_sel_pin,
    input address_strap_pin,
    input shared_io_five,
    input shared_io_six,
    output shared_io_seven_o,
    output shared_io_seven_oe
  );

  modport host (
    output slave_select_n,
    output shared_io_five,
    output shared_io_six,
    input shared_io_seven
  );
endinterface

// ===== shp_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on mclk; no crossing inside.
module shp_buf
  import shp_pkg::*;
#(
  parameter int W = 14
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  typedef struct packed {
    logic [1:0] cnt;
    logic [W-1:0] head;
    logic [W-1:0] tail;
  } shp_buf_st_t;

  shp_buf_st_t st_reg;
  shp_buf_st_t st_next;
  logic push;
  logic pop;

  assign in_ready = (st_reg.cnt != 2'h2);
  assign out_valid = (st_reg.cnt != 2'h0);
  assign out_data = st_reg.head;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (pop) begin
      st_next.head = st_reg.tail;
    end
    if (push) begin
      if (st_reg.cnt == 2'h0 || (st_reg.cnt == 2'h1 && pop)) begin
        st_next.head = in_data;
      end else begin
        st_next.tail = in_data;
      end
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ===== shp_host.sv
// Host end: SPI master that runs burst reads and burst writes.
// Assumes the device end samples its pins through synchronisers.
module shp_host
  import shp_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  shp_if.host pins,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_count,
  input wire logic wdata_valid,
  output logic wdata_ready,
  input wire logic [BYTE_W-1:0] wdata,
  output logic rdata_valid,
  output logic [BYTE_W-1:0] rdata
);

  localparam int HALF = (SCK_HALF < SCK_MIN_HALF) ? SCK_MIN_HALF : SCK_HALF;

  typedef struct packed {
    shp_hph_t ph;
    logic [7:0] div;
    logic sck;
    logic ss_n;
    logic [BYTE_W-1:0] tx;
    logic [BYTE_W-1:0] rx;
    logic [2:0] bit_cnt;
    logic [7:0] idx;
    logic [7:0] count;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [1:0] miso_s;
    logic rdata_v;
    logic [BYTE_W-1:0] rdata;
  } shp_host_st_t;

  shp_host_st_t st_reg;
  shp_host_st_t st_next;
  logic tick;

  assign tick = (st_reg.div == 8'(HALF - 1));
  assign cmd_ready = (st_reg.ph == SHP_HPH_IDLE);
  assign wdata_ready = (st_reg.ph == SHP_HPH_LOAD) && !st_reg.rd;

  always_comb begin
    st_next = st_reg;
    st_next.rdata_v = 1'b0;
    st_next.miso_s = {st_reg.miso_s[0], pins.shared_io_seven};
    st_next.div = tick ? 8'h00 : st_reg.div + 8'h01;
    unique case (st_reg.ph)
      SHP_HPH_IDLE: begin
        st_next.div = 8'h00;
        if (cmd_valid) begin
          st_next.rd = cmd_read;
          st_next.addr = cmd_addr;
          st_next.count = cmd_count;
          st_next.idx = 8'h00;
          st_next.bit_cnt = 3'h0;
          st_next.tx = {cmd_read, cmd_addr, ADDR_PAD};
          st_next.ss_n = 1'b0;
          st_next.ph = SHP_HPH_SEL;
        end
      end
      SHP_HPH_SEL: begin
        if (tick) begin
          st_next.ph = SHP_HPH_SHIFT;
        end
      end
      SHP_HPH_SHIFT: begin
        if (tick) begin
          st_next.sck = !st_reg.sck;
          if (!st_reg.sck) begin
            st_next.rx = {st_reg.rx[BYTE_W-2:0], st_reg.miso_s[1]};
          end else if (st_reg.bit_cnt == LAST_BIT) begin
            st_next.bit_cnt = 3'h0;
            if (st_reg.rd && st_reg.idx != 8'h00) begin
              st_next.rdata_v = 1'b1;
              st_next.rdata = st_reg.rx;
            end
            if (st_reg.idx == st_reg.count) begin
              st_next.ss_n = 1'b1;
              st_next.ph = SHP_HPH_END;
            end else begin
              st_next.idx = st_reg.idx + 8'h01;
              st_next.ph = SHP_HPH_LOAD;
            end
          end else begin
            st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            st_next.tx = {st_reg.tx[BYTE_W-2:0], 1'b0};
          end
        end
      end
      SHP_HPH_LOAD: begin
        st_next.div = 8'h00;
        if (st_reg.rd) begin
          st_next.ph = SHP_HPH_SHIFT;
          if (st_reg.idx == st_reg.count) begin
            st_next.tx = END_BYTE;
          end else begin
            st_next.tx = {RW_READ, st_reg.addr + st_reg.idx[ADDR_W-1:0],
                          ADDR_PAD};
          end
        end else if (wdata_valid) begin
          st_next.tx = wdata;
          st_next.ph = SHP_HPH_SHIFT;
        end
      end
      SHP_HPH_END: begin
        if (tick) begin
          st_next.ph = SHP_HPH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '{
        ph: SHP_HPH_IDLE,
        div: 8'h00,
        sck: 1'b0,
        ss_n: 1'b1,
        tx: '0,
        rx: '0,
        bit_cnt: 3'h0,
        idx: 8'h00,
        count: 8'h00,
        rd: 1'b0,
        addr: '0,
        miso_s: 2'h3,
        rdata_v: 1'b0,
        rdata: '0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins.shared_io_six = st_reg.tx[BYTE_W-1];
  assign pins.shared_io_five = st_reg.sck;
  assign pins.slave_select_n = st_reg.ss_n;
  assign rdata_valid = st_reg.rdata_v;
  assign rdata = st_reg.rdata;
endmodule

// ===== shp_checker.sv
// Assertions on the pin bundle between the host end and the device end.
// Assumes the host end holds SCK high for HALF cycles per bit.
module shp_checker
  import shp_pkg::*;
#(
  parameter int HALF = SCK_HALF_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic slave_select_n,
  input wire logic iface_sel_pin,
  input wire logic address_strap_pin,
  input wire logic shared_io_five,
  input wire logic shared_io_six,
  input wire logic shared_io_seven_o,
  input wire logic shared_io_seven_oe
);
  typedef struct packed {
    logic sck;
    logic [7:0] hi;
    logic [7:0] rises;
  } shp_chk_t;
  shp_chk_t chk_reg;
  shp_chk_t chk_next;

  // ********
  // Counters
  // ********
  always_comb begin
    chk_next = chk_reg;
    chk_next.sck = shared_io_five;
    chk_next.hi = shared_io_five ? chk_reg.hi + 8'h01 : 8'h00;
    if (slave_select_n) begin
      chk_next.rises = 8'h00;
    end else if (shared_io_five && !chk_reg.sck) begin
      chk_next.rises = chk_reg.rises + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      chk_reg <= '0;
    end else begin
      chk_reg <= chk_next;
    end
  end

  // **********
  // Assertions
  // **********
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sck_idle_low_a: assert property (
    slave_select_n |-> !shared_io_five)
    else $error("sck moved while deselected");
  miso_release_a: assert property (
    slave_select_n [*4] |-> !shared_io_seven_oe)
    else $error("miso driven while deselected");
  miso_drive_a: assert property (
    $fell(slave_select_n) && address_strap_pin && !iface_sel_pin
    |-> ##[1:6] shared_io_seven_oe)
    else $error("miso not driven in frame");
  detect_first_a: assert property (
    $fell(srst) |-> !shared_io_seven_oe [*4])
    else $error("miso driven before detection");
  strap_mode_a: assert property (
    iface_sel_pin || !address_strap_pin |-> !shared_io_seven_oe)
    else $error("miso driven outside serial mode");
  mosi_hold_a: assert property (
    shared_io_five && $past(shared_io_five) |-> $stable(shared_io_six))
    else $error("mosi changed while sck high");
  miso_hold_a: assert property (
    $rose(shared_io_five) && shared_io_seven_oe
    |-> $stable(shared_io_seven_o) ##1 $stable(shared_io_seven_o))
    else $error("miso changed at rising sck");
  sck_high_len_a: assert property (
    $fell(shared_io_five) |-> chk_reg.hi == 8'(HALF))
    else $error("sck high time wrong");
  whole_bytes_a: assert property (
    $rose(slave_select_n) |-> chk_reg.rises[2:0] == 3'h0)
    else $error("frame ended inside a byte");
endmodule

// ===== spi_host_port_with_detect_tb_top.sv
// Bench joining the host end and the device end through one bundle.
// A second device end on its own bundle is driven bit by bit here.
module spi_host_port_with_detect_tb_top
  import shp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [7:0] cmd_count = 8'h01;
  logic wdata_valid = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic wr_ready = 1'b1;
  logic [7:0] rd_data = 8'h00;
  logic sck_d = 1'b0;
  logic [2:0] bitn = 3'h0;
  logic cmd_ready, wdata_ready, rdata_valid, detect_done, rd_strobe;
  logic wr_valid, wr_overrun, wr_valid_2;
  logic [7:0] rdata, wr_data, wr_data_2, mosi_sh, miso_sh;
  logic [ADDR_W-1:0] rd_addr, wr_addr, wr_addr_2;
  shp_mode_t mode, mode_2;
  logic [15:0] wq[$], wq2[$], rq[$], mosi_q[$], miso_q[$];
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_over = 0;
  int n_rd = 0;
  shp_if pins();
  shp_if pins_2();

  shp_host #(.SCK_HALF(SCK_HALF_DEF)) i_shp_host (
    .mclk, .srst, .pins(pins.host), .cmd_valid, .cmd_ready, .cmd_read,
    .cmd_addr, .cmd_count, .wdata_valid, .wdata_ready, .wdata,
    .rdata_valid, .rdata);
  shp_dev i_shp_dev (
    .mclk, .srst, .pins(pins.dev), .mode, .detect_done, .rd_strobe,
    .rd_addr, .rd_data, .wr_valid, .wr_ready, .wr_addr, .wr_data,
    .wr_overrun);
  shp_dev i_shp_dev_2 (
    .mclk, .srst, .pins(pins_2.dev), .mode(mode_2), .detect_done(),
    .rd_strobe(), .rd_addr(), .rd_data(8'h00), .wr_valid(wr_valid_2),
    .wr_ready(1'b1), .wr_addr(wr_addr_2), .wr_data(wr_data_2),
    .wr_overrun());
  shp_checker #(.HALF(SCK_HALF_DEF)) i_shp_checker (
    .mclk, .srst, .slave_select_n(pins.slave_select_n),
    .iface_sel_pin(pins.iface_sel_pin),
    .address_strap_pin(pins.address_strap_pin),
    .shared_io_five(pins.shared_io_five),
    .shared_io_six(pins.shared_io_six),
    .shared_io_seven_o(pins.shared_io_seven_o),
    .shared_io_seven_oe(pins.shared_io_seven_oe));

  always #(MCLK_PERIOD_NS / 2) mclk = ~mclk;

  // ********
  // Monitors
  // ********
  function automatic logic [7:0] pat(input logic [5:0] a);
    return {a, 2'b11} ^ 8'h5A;
  endfunction

  // Register file stand-in: answers a read strobe within the same cycle, at the falling edge.
  always @(negedge mclk) if (rd_strobe) rd_data <= pat(rd_addr);

  always @(posedge mclk) begin
    cycles++;
    if (wr_valid && wr_ready) wq.push_back({2'b00, wr_addr, wr_data});
    if (wr_valid_2) wq2.push_back({2'b00, wr_addr_2, wr_data_2});
    if (rdata_valid) rq.push_back({8'h00, rdata});
    if (wr_overrun) n_over++;
    if (rd_strobe) n_rd++;
    sck_d <= pins.shared_io_five;
    if (pins.slave_select_n) begin
      bitn <= 3'h0;
    end else if (pins.shared_io_five && !sck_d) begin
      mosi_sh = {mosi_sh[6:0], pins.shared_io_six};
      miso_sh = {miso_sh[6:0], pins.shared_io_seven};
      bitn <= bitn + 3'h1;
      if (bitn == 3'h7) begin
        mosi_q.push_back({8'h00, mosi_sh});
        miso_q.push_back({8'h00, miso_sh});
      end
    end
    if (cycles == 6000) begin
      err_count++;
      report_and_stop();
    end
  end

  // *****
  // Tasks
  // *****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Called at a falling edge; returns once the frame is over.
  task automatic host_cmd(input logic rd, input logic [5:0] a,
                          input logic [7:0] n, input logic [7:0] d0);
    int i;
    logic t;
    i = 0;
    t = 1'b0;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_count = n;
    wdata_valid = !rd;
    wdata = d0;
    while (cmd_valid || wdata_valid) begin
      @(posedge mclk);
      if (cmd_ready) t = 1'b1;
      if (wdata_valid && wdata_ready) i++;
      @(negedge mclk);
      if (t) cmd_valid = 1'b0;
      wdata = d0 + 8'(i);
      if (i == n) wdata_valid = 1'b0;
    end
    do @(posedge mclk); while (!cmd_ready);
    repeat (20) @(negedge mclk);
  endtask

  task automatic t_straps();
    logic [1:0] st[3] = '{2'b00, 2'b10, 2'b01};
    shp_mode_t em[3] = '{SHP_MODE_UART, SHP_MODE_I2C, SHP_MODE_SPI};
    for (int k = 0; k < 3; k++) begin
      srst = 1'b1;
      {pins.iface_sel_pin, pins.address_strap_pin} = st[k];
      repeat (4) @(negedge mclk);
      srst = 1'b0;
      wq.delete();
      @(negedge mclk);
      check(16'(mode), 16'(SHP_MODE_NONE));
      repeat (7) @(negedge mclk);
      check(16'(mode), 16'(em[k]));
      host_cmd(1'b0, 6'h09, 8'h01, 8'h77);
      check(16'(wq.size()), (k == 2) ? 16'h0001 : 16'h0000);
    end
    check(wq[0], {2'b00, 6'h09, 8'h77});
    $display("strap test done");
  endtask

  task automatic t_read();
    logic [5:0] a;
    rq.delete();
    mosi_q.delete();
    miso_q.delete();
    n_rd = 0;
    // The address wraps from the top register to register zero.
    host_cmd(1'b1, 6'h3E, 8'h03, 8'h00);
    for (int k = 0; k < 3; k++) begin
      a = 6'h3E + 6'(k);
      check(rq[k], {8'h00, pat(a)});
      check(miso_q[k + 1], {8'h00, pat(a)});
      check(mosi_q[k], {8'h00, 1'b1, a, 1'b0});
    end
    check(mosi_q[3], 16'h0000);
    check(16'(n_rd), 16'h0003);
    $display("read test done");
  endtask

  task automatic t_write();
    wq.delete();
    mosi_q.delete();
    n_over = 0;
    wr_ready = 1'b0;
    host_cmd(1'b0, 6'h15, 8'h03, 8'hA0);
    check(16'(wq.size()), 16'h0000);
    check(16'(n_over), 16'h0001);
    wr_ready = 1'b1;
    repeat (4) @(negedge mclk);
    check(wq[0], {2'b00, 6'h15, 8'hA0});
    check(wq[1], {2'b00, 6'h15, 8'hA1});
    check(16'(wq.size()), 16'h0002);
    check(mosi_q[0], 16'h002A);
    $display("write test done");
  endtask

  task automatic spi_bits(input logic [7:0] b, input int nb);
    for (int k = 7; k > 7 - nb; k--) begin
      pins_2.shared_io_six = b[k];
      repeat (4) @(negedge mclk);
      pins_2.shared_io_five = 1'b1;
      repeat (4) @(negedge mclk);
      pins_2.shared_io_five = 1'b0;
    end
  endtask

  task automatic t_abort();
    wq2.delete();
    pins_2.slave_select_n = 1'b0;
    repeat (4) @(negedge mclk);
    spi_bits(8'hFF, 3);
    repeat (4) @(negedge mclk);
    pins_2.slave_select_n = 1'b1;
    pins_2.shared_io_six = ~pins_2.shared_io_six;
    repeat (8) @(negedge mclk);
    pins_2.slave_select_n = 1'b0;
    repeat (4) @(negedge mclk);
    spi_bits(8'h57, 8);
    spi_bits(8'hC3, 8);
    spi_bits(8'h3C, 8);
    repeat (4) @(negedge mclk);
    pins_2.slave_select_n = 1'b1;
    repeat (8) @(negedge mclk);
    check(wq2[0], {2'b00, 6'h2B, 8'hC3});
    check(wq2[1], {2'b00, 6'h2B, 8'h3C});
    check(16'(wq2.size()), 16'h0002);
    $display("abort test done");
  endtask

  initial begin
    pins.iface_sel_pin = 1'b0;
    pins.address_strap_pin = 1'b1;
    pins_2.iface_sel_pin = 1'b0;
    pins_2.address_strap_pin = 1'b1;
    pins_2.slave_select_n = 1'b1;
    pins_2.shared_io_five = 1'b0;
    pins_2.shared_io_six = 1'b0;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    repeat (8) @(negedge mclk);
    check(16'(mode_2), 16'(SHP_MODE_SPI));
    check(16'(detect_done), 16'h0001);
    t_straps();
    t_read();
    t_write();
    t_abort();
    report_and_stop();
  end
endmodule
